// ===== include/rtc_consts.svh
// Purpose: Constants for the rotate-through-carry unit
// Assumes: 14-bit instruction word, 8-bit data path
// Notes:   Opcode field is bits 13..8 with the destination bit masked off
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define RTC_OPC_MSB      13
`define RTC_OPC_LSB      8
`define RTC_OPC_ROTL     6'h0D
`define RTC_OPC_ROTR     6'h0C
`define RTC_DEST_BIT     7
`define RTC_ADDR_MSB     6
`define RTC_PHASE_COUNT  4
`define RTC_DATA_RST     8'h00
`endif

// ===== include/rtc_pkg.sv
// Purpose: Types for the rotate-through-carry unit
// Assumes: Nothing beyond the constants header
// Notes:   Phase enum follows a Gray sequence
package rtc_pkg;
    typedef enum logic [1:0] {
        RTC_PH_ONE   = 2'b00,
        RTC_PH_TWO   = 2'b01,
        RTC_PH_THREE = 2'b11,
        RTC_PH_FOUR  = 2'b10
    } rtc_phase_t;
    typedef enum logic [1:0] {
        RTC_OP_NONE  = 2'b00,
        RTC_OP_LEFT  = 2'b01,
        RTC_OP_RIGHT = 2'b10
    } rtc_op_t;
endpackage : rtc_pkg

// ===== logic/rtc_rotator.sv
// Purpose: Combinational one-bit rotate through carry
// Assumes: Operation selected by the caller
// Notes:   Passes operand and carry through when no rotate is selected
`timescale 1ns/1ps
`default_nettype none
module rtc_rotator (
    input  wire logic            [7:0] operand,
    input  wire logic                  carry_in,
    input  wire rtc_pkg::rtc_op_t      op,
    output logic                 [7:0] result,
    output logic                       carry_out
);
    import rtc_pkg::*;
    // Rotate select
    always_comb begin
        result    = operand;
        carry_out = carry_in;
        unique case (op)
            RTC_OP_LEFT: begin
                result    = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            RTC_OP_RIGHT: begin
                result    = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
            default: begin
                result    = operand;
                carry_out = carry_in;
            end
        endcase
    end
endmodule : rtc_rotator
`default_nettype wire

// ===== logic/rtc_unit.sv
// Purpose: Rotate-through-carry datapath slice with four-phase sequencing
// Assumes: Decoder presents instr with instr_valid in quarter phase one
// Notes:   Only the carry flag is touched; other flags stay with the core
//          The quarter phases run freely from reset; the decoder aligns
//          its words to phase one and holds them there for one cycle
//          W and the carry flag live in the core, which applies the
//          write strobes at the end of phase four
//          A word that is not a rotate leaves every strobe low
//          Back-to-back rotates need no gap between their words
// Functional notes
// - Left rotate: carry into bit0, bit7 out
// - Right rotate: carry into bit7, bit0 out
// - Destination clear writes working register and carry, not the file register
// - Destination set writes back source file register
// - Four phases: decode, read, compute, write
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
module rtc_unit (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                instr_valid,
    input  wire logic         [13:0] instr,
    input  wire logic                carry_in,
    input  wire logic          [7:0] file_rdata,
    output logic               [6:0] file_addr,
    output logic                     file_rd,
    output logic                     file_we,
    output logic               [7:0] file_wdata,
    output logic                     w_we,
    output logic               [7:0] w_wdata,
    output logic                     carry_we,
    output logic                     carry_out,
    output logic                     busy,
    output rtc_pkg::rtc_phase_t      phase
);
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    // Opcode classification, shared by the accept path
    function automatic rtc_op_t rtc_decode(input logic [13:0] word);
        rtc_op_t op;
        op = RTC_OP_NONE;
        if (word[`RTC_OPC_MSB:`RTC_OPC_LSB] == `RTC_OPC_ROTL) begin
            op = RTC_OP_LEFT;
        end else if (word[`RTC_OPC_MSB:`RTC_OPC_LSB] == `RTC_OPC_ROTR) begin
            op = RTC_OP_RIGHT;
        end
        return op;
    endfunction : rtc_decode

    // Gray code of the quarter phase at walk position idx
    function automatic rtc_phase_t rtc_gray(input logic [1:0] idx);
        return rtc_phase_t'(idx ^ (idx >> 1));
    endfunction : rtc_gray

    // Sequencer state and the fields taken in phase one
    rtc_phase_t phase_r;
    rtc_op_t    op_r;
    logic [6:0] addr_r;
    logic       dest_r;
    logic       active_r;

    // Operand, carry and result held between the phases
    logic [7:0] operand_r;
    logic       cin_r;
    logic [7:0] result_r;
    logic       cres_r;

    // Rotator outputs
    logic [7:0] rot_res;
    logic       rot_c;

    // One flag per quarter phase, decoded once and shared
    logic [3:0] phase_hot;
    logic       in_one;
    logic       in_two;
    logic       in_three;
    logic       in_four;

    // ------------------------------------------------------------
    // Phase flags
    // ------------------------------------------------------------
    // Walk position g is live when the counter shows its Gray code
    for (genvar g = 0; g < `RTC_PHASE_COUNT; g++) begin : g_phase
        assign phase_hot[g] = (phase_r == rtc_gray(2'(g)));
    end

    // Named views of the flags for the phase-gated processes
    assign in_one   = phase_hot[0];
    assign in_two   = phase_hot[1];
    assign in_three = phase_hot[2];
    assign in_four  = phase_hot[3];

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    // Four quarter phases run continuously
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_r <= RTC_PH_ONE;
        end else begin
            unique case (phase_r)
                RTC_PH_ONE:   phase_r <= RTC_PH_TWO;
                RTC_PH_TWO:   phase_r <= RTC_PH_THREE;
                RTC_PH_THREE: phase_r <= RTC_PH_FOUR;
                RTC_PH_FOUR:  phase_r <= RTC_PH_ONE;
            endcase
        end
    end

    // Take the operation in quarter phase one; an idle slot clears it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_r <= RTC_OP_NONE;
        end else if (in_one) begin
            op_r <= instr_valid ? rtc_decode(instr) : RTC_OP_NONE;
        end
    end

    // Latch the address field and destination bit of a presented word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_r <= 7'h00;
            dest_r <= 1'b0;
        end else if (in_one && instr_valid) begin
            addr_r <= instr[`RTC_ADDR_MSB:0];
            dest_r <= instr[`RTC_DEST_BIT];
        end
    end

    // Busy from the edge that takes a rotate to the end of phase four
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_r <= 1'b0;
        end else if (in_one) begin
            active_r <= instr_valid && (rtc_decode(instr) != RTC_OP_NONE);
        end else if (in_four) begin
            active_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read and compute
    // ------------------------------------------------------------
    // Capture the file register in quarter phase two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            operand_r <= `RTC_DATA_RST;
        end else if (in_two && active_r) begin
            operand_r <= file_rdata;
        end
    end

    // Capture the carry flag alongside the operand
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cin_r <= 1'b0;
        end else if (in_two && active_r) begin
            cin_r <= carry_in;
        end
    end

    rtc_rotator u_rot (
        .operand   (operand_r),
        .carry_in  (cin_r),
        .op        (op_r),
        .result    (rot_res),
        .carry_out (rot_c)
    );

    // Register the rotated value in quarter phase three
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_r <= `RTC_DATA_RST;
        end else if (in_three && active_r) begin
            result_r <= rot_res;
        end
    end

    // Register the new carry with the rotated value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cres_r <= 1'b0;
        end else if (in_three && active_r) begin
            cres_r <= rot_c;
        end
    end

    // ------------------------------------------------------------
    // Write-back
    // ------------------------------------------------------------
    // Strobes in quarter phase four pick the destination
    always_comb begin
        file_we  = 1'b0;
        w_we     = 1'b0;
        carry_we = 1'b0;
        if (active_r && in_four) begin
            carry_we = 1'b1;
            if (dest_r) begin
                file_we = 1'b1;
            end else begin
                w_we    = 1'b1;
            end
        end
    end

    // Read strobe: the file array shows valid data only while it stands
    assign file_rd = active_r && in_two;

    // Data outputs straight from the holding flip-flops
    assign file_addr  = addr_r;
    assign file_wdata = result_r;
    assign w_wdata    = result_r;
    assign carry_out  = cres_r;
    assign busy       = active_r;
    assign phase      = phase_r;
endmodule : rtc_unit
`default_nettype wire

// ===== verification/rtc_unit_asserts.sv
// Purpose: Port assertions for the rotate unit
// Assumes: Phase runs freely from reset
// Notes:   Operand and carry captured in phase two
`timescale 1ns/1ps
`default_nettype none
module rtc_unit_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        instr_valid,
    input wire logic [13:0] instr,
    input wire logic        carry_in,
    input wire logic  [7:0] file_rdata,
    input wire logic  [6:0] file_addr,
    input wire logic        file_we,
    input wire logic        w_we,
    input wire logic  [7:0] w_wdata,
    input wire logic        carry_we,
    input wire logic        carry_out,
    input wire logic        busy,
    input wire rtc_pkg::rtc_phase_t phase
);
    import rtc_pkg::*;
    logic [7:0] opnd_r;
    logic       cin_r;
    logic       take;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A rotate word accepted in phase one
    assign take = phase == RTC_PH_ONE && instr_valid && instr[13:9] == 5'h06;
    // Operand and carry as the unit sampled them
    always_ff @(posedge clk) begin
        if (phase == RTC_PH_TWO) begin
            opnd_r <= file_rdata;
            cin_r  <= carry_in;
        end
    end
    sequence walk_s;
        phase == RTC_PH_TWO ##1 phase == RTC_PH_THREE ##1 phase == RTC_PH_FOUR;
    endsequence
    a_left_rotate: assert property (take && instr[8] |-> ##3 carry_we &&
        w_wdata == {opnd_r[6:0], cin_r} && carry_out == opnd_r[7])
        else $error("left rotate wrong");
    a_right_rotate: assert property (take && !instr[8] |-> ##3 carry_we &&
        w_wdata == {cin_r, opnd_r[7:1]} && carry_out == opnd_r[0])
        else $error("right rotate wrong");
    a_dest_clear: assert property (take && !instr[7] |-> ##3 w_we && !file_we)
        else $error("w write wrong");
    a_dest_set: assert property (take && instr[7] |-> ##3 file_we && !w_we &&
        file_addr == $past(instr[6:0], 3)) else $error("file write wrong");
    a_phase_walk: assert property (phase == RTC_PH_ONE |=> walk_s)
        else $error("phase order wrong");
    a_busy_span: assert property (take |=> busy [*3] ##1 !busy)
        else $error("busy span wrong");
    a_write_phase: assert property (w_we || file_we |-> phase == RTC_PH_FOUR)
        else $error("write outside phase four");
    a_addr_field: assert property (take |=> file_addr == $past(instr[6:0]))
        else $error("address wrong");
endmodule : rtc_unit_chk
bind rtc_unit rtc_unit_chk u_chk (.clk, .rst_n, .instr_valid, .instr,
    .carry_in, .file_rdata, .file_addr, .file_we, .w_we, .w_wdata,
    .carry_we, .carry_out, .busy, .phase);
`default_nettype wire

// ===== verification/rtc_file_model.sv
// Purpose: File register array beside the rotate unit
// Assumes: Writes land on the edge ending phase four
// Notes:   Unselected reads show flipped data
`timescale 1ns/1ps
`default_nettype none
module rtc_file_model (
    input wire logic       clk,
    input wire logic [6:0] file_addr,
    input wire logic       file_rd,
    input wire logic       file_we,
    input wire logic [7:0] file_wdata,
    output logic     [7:0] file_rdata
);
    logic [7:0] mem [128];
    // Data valid only while the unit reads
    assign file_rdata = file_rd ? mem[file_addr] : ~mem[file_addr];
    // Write port and preset contents
    always @(posedge clk) begin
        if (file_we) mem[file_addr] <= file_wdata;
    end
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'hE6 ^ 8'(i);
    end
endmodule : rtc_file_model
`default_nettype wire

// ===== verification/rotate_through_carry_unit_bench.sv
// Purpose: Self-checking bench for the rotate unit
// Assumes: Inputs change at the falling edge
// Notes:   Word held valid past phase one to show it is ignored
`timescale 1ns/1ps
`default_nettype none
module rotate_through_carry_unit_bench;
    import rtc_pkg::*;
    logic        clk, rst_n, instr_valid, carry_in, file_rd, file_we;
    logic        w_we, carry_we, carry_out, busy;
    logic [13:0] instr;
    logic  [7:0] file_rdata, file_wdata, w_wdata, old;
    logic  [6:0] file_addr;
    rtc_phase_t  phase;
    integer      seed = 79, bad_count = 0, checked = 0, i;
    rtc_unit DUT (.clk, .rst_n, .instr_valid, .instr, .carry_in, .file_rdata,
        .file_addr, .file_rd, .file_we, .file_wdata, .w_we, .w_wdata,
        .carry_we, .carry_out, .busy, .phase);
    rtc_file_model PM (.clk, .file_addr, .file_rd, .file_we, .file_wdata,
        .file_rdata);
    // Free-running 4 ns clock
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task stop_test;
        if (bad_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [8:0] e, input logic [8:0] s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // New carry above the rotated byte
    function automatic logic [8:0] exp_rot(logic [13:0] w, logic [7:0] d,
        logic c);
        return w[8] ? {d[7], d[6:0], c} : {d[0], c, d[7:1]};
    endfunction : exp_rot
    task run(input logic [13:0] w, input logic c, input logic v);
        logic       rot;
        logic [8:0] e;
        rot = v && (w[13:9] == 5'h06);
        for (i = 0; i < 8 && phase !== RTC_PH_ONE; i++) @(negedge clk);
        if (i == 8) begin
            bad_count++;
            stop_test;
        end
        old = PM.mem[w[6:0]];
        e = exp_rot(w, old, c);
        instr_valid = v;
        instr = w;
        carry_in = c;
        @(negedge clk);
        chk("rd", {8'h00, rot}, {8'h00, file_rd});
        if (rot) chk("addr", {2'b0, w[6:0]}, {2'b0, file_addr});
        repeat (2) @(negedge clk);
        chk("we", {6'h00, rot, rot & ~w[7], rot & w[7]},
            {6'h00, carry_we, w_we, file_we});
        if (rot) chk("data", e, {carry_out, w_wdata});
        @(negedge clk);
        chk("file", {1'b0, rot & w[7] ? e[7:0] : old},
            {1'b0, PM.mem[w[6:0]]});
    endtask : run
    // Reset, corner words, then random words
    initial begin
        rst_n = 0;
        instr_valid = 0;
        instr = 14'h0000;
        carry_in = 0;
        repeat (20) @(negedge clk);
        rst_n = 1;
        run(14'h0D00, 1'b0, 1'b1);
        run(14'h0C00, 1'b0, 1'b1);
        run(14'h0DFF, 1'b1, 1'b1);
        run(14'h0CFF, 1'b1, 1'b1);
        run(14'h0DAA, 1'b1, 1'b0);
        run(14'h0E55, 1'b1, 1'b1);
        for (int k = 0; k < 60; k++) begin
            run(k % 5 ? {5'h06, 9'($random(seed))} : 14'($random(seed)),
                1'($random(seed)), k % 7 != 3);
        end
        stop_test;
    end
endmodule : rotate_through_carry_unit_bench
`default_nettype wire
